// ---- phybc_pkg.sv ----
`default_nettype none

package phybc_pkg;

  // Timing of the software reset pulse
  localparam int CLK_PERIOD_NS = 100;
  localparam int SWRST_TIME_NS = 1000;
  localparam int SWRST_CYCLES  = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SWRST_CNT_LOAD = 4'(SWRST_CYCLES);

  // Management register addresses
  localparam logic [4:0] BMC_ADDR = 5'h00;
  localparam logic [4:0] EVT_ADDR = 5'h11;

  // Basic mode control bit positions
  localparam int BMC_RESET_BIT    = 15;
  localparam int BMC_LOOPBACK_BIT = 14;
  localparam int BMC_SPEED_BIT    = 13;
  localparam int BMC_AN_EN_BIT    = 12;
  localparam int BMC_PWDN_BIT     = 11;
  localparam int BMC_ISOLATE_BIT  = 10;
  localparam int BMC_AN_RST_BIT   = 9;
  localparam int BMC_DUPLEX_BIT   = 8;
  localparam int BMC_COLL_BIT     = 7;

  // Values after reset
  localparam logic RST_LOOPBACK = 1'b0;
  localparam logic RST_SPEED    = 1'b1;
  localparam logic RST_AN_EN    = 1'b1;
  localparam logic RST_PWDN     = 1'b0;
  localparam logic RST_ISOLATE  = 1'b0;
  localparam logic RST_DUPLEX   = 1'b1;
  localparam logic RST_COLL     = 1'b0;
  localparam logic [6:0] BMC_RESERVED_VAL = 7'h00;

  // Event status layout; upper field is hardwired, value arbitrary
  localparam int EVT_RX_ERR_BIT  = 0;
  localparam int EVT_LINK_BIT    = 1;
  localparam int EVT_FCAR_BIT    = 2;
  localparam int EVT_ENERGY_BIT  = 3;
  localparam int EVT_COUNT       = 4;
  localparam logic [3:0] EVT_FIXED_FIELD = 4'h5;

  // Serial management frame
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [4:0] HDR_LAST      = 5'h0C;
  localparam logic [4:0] DATA_LAST     = 5'h0F;

  // Kinds of status bit
  typedef enum logic [1:0] {
    EVK_LATCH_HIGH,
    EVK_LATCH_LOW,
    EVK_CLEAR_ON_READ,
    EVK_SELF_CLEAR
  } phybc_evk_e;

endpackage : phybc_pkg

`default_nettype wire

// ---- phybc_mgmt_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface phybc_mgmt_if;
  logic        rd_stb;
  logic        wr_stb;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [4:0]  phy_addr;

  modport serial (output rd_stb, output wr_stb, output reg_addr, output wr_data,
                  input rd_data, input phy_addr);
  modport core   (input rd_stb, input wr_stb, input reg_addr, input wr_data,
                  output rd_data, output phy_addr);
endinterface : phybc_mgmt_if

`default_nettype wire

// ---- phybc_event_bit.sv ----
`timescale 1ns/100ps
`default_nettype none

module phybc_event_bit #(
  parameter phybc_pkg::phybc_evk_e KIND = phybc_pkg::EVK_LATCH_HIGH
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic event_in,
  input  wire logic read_clr,
  output logic      bit_q
);

  // Event beats the read-clear in the same cycle so nothing is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      bit_q <= (KIND == phybc_pkg::EVK_LATCH_LOW);
    end else begin
      unique case (KIND)
        phybc_pkg::EVK_LATCH_HIGH,
        phybc_pkg::EVK_CLEAR_ON_READ: begin
          if (event_in) begin
            bit_q <= 1'b1;
          end else if (read_clr) begin
            bit_q <= 1'b0;
          end
        end
        phybc_pkg::EVK_LATCH_LOW: begin
          if (!event_in) begin
            bit_q <= 1'b0;
          end else if (read_clr) begin
            bit_q <= 1'b1;
          end
        end
        phybc_pkg::EVK_SELF_CLEAR: begin
          bit_q <= event_in;
        end
      endcase
    end
  end

endmodule : phybc_event_bit

`default_nettype wire

// ---- phybc_mdio_serial.sv ----
`timescale 1ns/100ps
`default_nettype none

module phybc_mdio_serial (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          mdc,
  input  wire logic          mdio_in,
  output logic               mdio_out,
  output logic               mdio_oe,
  phybc_mgmt_if.serial       mg
);

  typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} phybc_ser_e;

  phybc_ser_e  state_q;
  logic        mdc_q;
  logic [5:0]  pre_cnt_q;
  logic [4:0]  cnt_q;
  logic [15:0] sh_q;
  logic        rd_q;
  logic        wr_q;
  logic        rise;
  logic [12:0] hdr;
  logic        hdr_ok;

  // MDC is sampled as an ordinary synchronous input
  always_ff @(posedge clk) begin
    if (rst) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  assign rise   = mdc & ~mdc_q;
  assign hdr    = {sh_q[11:0], mdio_in};
  assign hdr_ok = hdr[12] && (hdr[9:5] == mg.phy_addr);

  // Frame engine; preamble suppression is not supported
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= ST_PRE;
      pre_cnt_q   <= 6'h00;
      cnt_q       <= 5'h00;
      sh_q        <= 16'h0000;
      rd_q        <= 1'b0;
      wr_q        <= 1'b0;
      mdio_out    <= 1'b0;
      mdio_oe     <= 1'b0;
      mg.rd_stb   <= 1'b0;
      mg.wr_stb   <= 1'b0;
      mg.reg_addr <= 5'h00;
      mg.wr_data  <= 16'h0000;
    end else begin
      mg.rd_stb <= 1'b0;
      mg.wr_stb <= 1'b0;
      if (rise) begin
        unique case (state_q)
          ST_PRE: begin
            if (mdio_in) begin
              if (pre_cnt_q != phybc_pkg::PREAMBLE_ONES) begin
                pre_cnt_q <= pre_cnt_q + 6'h01;
              end
            end else begin
              pre_cnt_q <= 6'h00;
              if (pre_cnt_q == phybc_pkg::PREAMBLE_ONES) begin
                state_q <= ST_HDR;
                cnt_q   <= 5'h00;
              end
            end
          end
          ST_HDR: begin
            sh_q  <= {sh_q[14:0], mdio_in};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == phybc_pkg::HDR_LAST) begin
              mg.reg_addr <= hdr[4:0];
              rd_q        <= hdr_ok && (hdr[11:10] == phybc_pkg::OP_READ);
              wr_q        <= hdr_ok && (hdr[11:10] == phybc_pkg::OP_WRITE);
              mg.rd_stb   <= hdr_ok && (hdr[11:10] == phybc_pkg::OP_READ);
              state_q     <= ST_TA;
              cnt_q       <= 5'h00;
            end
          end
          ST_TA: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h00) begin
              mdio_oe  <= rd_q;    // Second turnaround bit driven low
              mdio_out <= 1'b0;
            end else begin
              mdio_out <= rd_q & mg.rd_data[15];
              sh_q     <= {mg.rd_data[14:0], 1'b0};
              state_q  <= ST_DATA;
              cnt_q    <= 5'h00;
            end
          end
          ST_DATA: begin
            cnt_q <= cnt_q + 5'h01;
            sh_q  <= {sh_q[14:0], mdio_in};
            if (rd_q) begin
              mdio_out <= sh_q[15];
            end
            if (cnt_q == phybc_pkg::DATA_LAST) begin
              mdio_oe    <= 1'b0;
              mdio_out   <= 1'b0;
              mg.wr_stb  <= wr_q;
              mg.wr_data <= {sh_q[14:0], mdio_in};
              rd_q       <= 1'b0;
              wr_q       <= 1'b0;
              state_q    <= ST_PRE;
            end
          end
        endcase
      end
    end
  end

endmodule : phybc_mdio_serial

`default_nettype wire

// ---- phybc_basic_control.sv ----
`timescale 1ns/100ps
`default_nettype none

module phybc_basic_control (
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  input  wire logic       MDC,
  input  wire logic       MDIO_IN,
  output logic            MDIO_OUT,
  output logic            MDIO_OE,
  input  wire logic [4:0] PHY_ADDR_STRAP,
  input  wire logic       DUPLEX_STRAP,
  input  wire logic       INTERRUPT_POWERDOWN_PIN_N,
  input  wire logic       AN_STARTED,
  input  wire logic       AN_RESULT_100,
  input  wire logic       AN_RESULT_FULL,
  input  wire logic       RX_ERROR,
  input  wire logic       LINK_OK,
  input  wire logic       FALSE_CARRIER,
  input  wire logic       ENERGY_DETECT,
  input  wire logic [3:0] MII_TXD,
  input  wire logic       MII_TX_EN,
  input  wire logic [3:0] LINE_RXD,
  input  wire logic       LINE_RX_DV,
  output logic      [3:0] MII_RXD,
  output logic            MII_RX_DV,
  output logic            MII_OE,
  output logic            SOFT_RESET,
  output logic            LOOPBACK,
  output logic            SPEED_100,
  output logic            FULL_DUPLEX,
  output logic            AN_ENABLE,
  output logic            AN_RESTART,
  output logic            POWER_DOWN,
  output logic            ISOLATE,
  output logic            COLLISION_TEST
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  phybc_mgmt_if mg ();

  logic        swrst_q;
  logic [3:0]  swrst_cnt_q;
  logic        swrst_done;
  logic        strap_load_q;
  logic        ctl_rst;
  logic        wr_ctl;
  logic        rd_evt;
  logic [15:0] wd;
  logic        loop_q;
  logic        speed_q;
  logic        an_en_q;
  logic        pwdn_q;
  logic        iso_q;
  logic        an_rst_q;
  logic        duplex_q;
  logic        coll_q;
  logic [4:0]  phy_addr_q;
  logic [15:0] rd_data_q;
  logic [phybc_pkg::EVT_COUNT-1:0] evt_in;
  logic [phybc_pkg::EVT_COUNT-1:0] evt_q;

  localparam phybc_pkg::phybc_evk_e EVT_KIND [phybc_pkg::EVT_COUNT] = '{
    phybc_pkg::EVK_LATCH_HIGH, phybc_pkg::EVK_LATCH_LOW,
    phybc_pkg::EVK_CLEAR_ON_READ, phybc_pkg::EVK_SELF_CLEAR};

  // Register image seen by a management read
  function automatic logic [15:0] read_word(input logic [4:0] addr,
                                            input logic [15:0] bmc,
                                            input logic [3:0] evt);
    logic [15:0] w;
    w = 16'h0000;
    if (addr == phybc_pkg::BMC_ADDR) begin
      w = bmc;
    end else if (addr == phybc_pkg::EVT_ADDR) begin
      w = {phybc_pkg::EVT_FIXED_FIELD, 8'h00, evt};
    end
    return w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Serial management engine

  phybc_mdio_serial u_serial (
    .clk      (CORE_CLK),
    .rst      (RST),
    .mdc      (MDC),
    .mdio_in  (MDIO_IN),
    .mdio_out (MDIO_OUT),
    .mdio_oe  (MDIO_OE),
    .mg       (mg.serial)
  );

  assign wd          = mg.wr_data;
  assign wr_ctl      = mg.wr_stb && (mg.reg_addr == phybc_pkg::BMC_ADDR) && !swrst_q;
  assign rd_evt      = mg.rd_stb && (mg.reg_addr == phybc_pkg::EVT_ADDR);
  assign mg.rd_data  = rd_data_q;
  assign mg.phy_addr = phy_addr_q;

  // Capture on the strobe edge so a clear-on-read sees the old value first
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rd_data_q <= 16'h0000;
    end else if (mg.rd_stb) begin
      rd_data_q <= read_word(mg.reg_addr,
                             {swrst_q, loop_q, speed_q, an_en_q, pwdn_q, iso_q,
                              an_rst_q, duplex_q, coll_q, phybc_pkg::BMC_RESERVED_VAL},
                             evt_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software reset and strap loading

  assign swrst_done = swrst_q && (swrst_cnt_q == 4'h1);
  assign ctl_rst    = RST || swrst_q;

  // Bit 15 reads one for the whole reset, then clears itself
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      swrst_q     <= 1'b0;
      swrst_cnt_q <= 4'h0;
    end else if (wr_ctl && wd[phybc_pkg::BMC_RESET_BIT]) begin
      swrst_q     <= 1'b1;
      swrst_cnt_q <= phybc_pkg::SWRST_CNT_LOAD;
    end else if (swrst_q) begin
      swrst_cnt_q <= swrst_cnt_q - 4'h1;
      swrst_q     <= !swrst_done;
    end
  end

  // Straps sampled one edge after either reset ends, never under reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      strap_load_q <= 1'b1;
    end else begin
      strap_load_q <= swrst_done;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      duplex_q   <= phybc_pkg::RST_DUPLEX;
      phy_addr_q <= 5'h00;
    end else if (strap_load_q) begin
      duplex_q   <= DUPLEX_STRAP;
      phy_addr_q <= PHY_ADDR_STRAP;
    end else if (wr_ctl) begin
      duplex_q   <= wd[phybc_pkg::BMC_DUPLEX_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields; a reset write ignores the rest of its word, except duplex bit 8, which the strap block loads

  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst || (wr_ctl && wd[phybc_pkg::BMC_RESET_BIT])) begin
      loop_q  <= phybc_pkg::RST_LOOPBACK;
      speed_q <= phybc_pkg::RST_SPEED;
      an_en_q <= phybc_pkg::RST_AN_EN;
      iso_q   <= phybc_pkg::RST_ISOLATE;
      coll_q  <= phybc_pkg::RST_COLL;
    end else if (wr_ctl && !wd[phybc_pkg::BMC_RESET_BIT]) begin
      loop_q  <= wd[phybc_pkg::BMC_LOOPBACK_BIT];
      speed_q <= wd[phybc_pkg::BMC_SPEED_BIT];
      an_en_q <= wd[phybc_pkg::BMC_AN_EN_BIT];
      iso_q   <= wd[phybc_pkg::BMC_ISOLATE_BIT];
      coll_q  <= wd[phybc_pkg::BMC_COLL_BIT];
    end
  end

  // Pin low forces the bit; the pin wins over a write of zero
  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst) begin
      pwdn_q <= phybc_pkg::RST_PWDN;
    end else if (!INTERRUPT_POWERDOWN_PIN_N) begin
      pwdn_q <= 1'b1;
    end else if (wr_ctl && !wd[phybc_pkg::BMC_RESET_BIT]) begin
      pwdn_q <= wd[phybc_pkg::BMC_PWDN_BIT];
    end
  end

  // Restart uses the enable of the same word; writing zero is ignored
  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst) begin
      an_rst_q <= 1'b0;
    end else if (wr_ctl && wd[phybc_pkg::BMC_AN_RST_BIT] && wd[phybc_pkg::BMC_AN_EN_BIT]
                 && !wd[phybc_pkg::BMC_RESET_BIT]) begin
      an_rst_q <= 1'b1;
    end else if (AN_STARTED) begin
      an_rst_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status bits

  assign evt_in = {ENERGY_DETECT, FALSE_CARRIER, LINK_OK, RX_ERROR};

  for (genvar i = 0; i < phybc_pkg::EVT_COUNT; i++) begin : g_evt
    phybc_event_bit #(
      .KIND (EVT_KIND[i])
    ) u_bit (
      .clk      (CORE_CLK),
      .rst      (ctl_rst),
      .event_in (evt_in[i]),
      .read_clr (rd_evt),
      .bit_q    (evt_q[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective mode outputs, registered for clean levels

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      SOFT_RESET     <= 1'b0;
      LOOPBACK       <= phybc_pkg::RST_LOOPBACK;
      SPEED_100      <= phybc_pkg::RST_SPEED;
      FULL_DUPLEX    <= phybc_pkg::RST_DUPLEX;
      AN_ENABLE      <= phybc_pkg::RST_AN_EN;
      AN_RESTART     <= 1'b0;
      POWER_DOWN     <= 1'b0;
      ISOLATE        <= phybc_pkg::RST_ISOLATE;
      COLLISION_TEST <= phybc_pkg::RST_COLL;
    end else begin
      SOFT_RESET     <= swrst_q;
      LOOPBACK       <= loop_q;
      SPEED_100      <= an_en_q ? AN_RESULT_100  : speed_q;
      FULL_DUPLEX    <= an_en_q ? AN_RESULT_FULL : duplex_q;
      AN_ENABLE      <= an_en_q;
      AN_RESTART     <= an_rst_q;
      POWER_DOWN     <= pwdn_q || !INTERRUPT_POWERDOWN_PIN_N;
      ISOLATE        <= iso_q;
      COLLISION_TEST <= coll_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // MII receive path; isolation releases the MAC-side outputs

  // Plain reset only: mode bits reset themselves, so path and flags stay in step
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MII_RXD   <= 4'h0;
      MII_RX_DV <= 1'b0;
      MII_OE    <= 1'b1;
    end else begin
      MII_OE <= !iso_q;
      if (iso_q) begin
        MII_RXD   <= 4'h0;
        MII_RX_DV <= 1'b0;
      end else if (loop_q) begin
        MII_RXD   <= MII_TXD;
        MII_RX_DV <= MII_TX_EN;
      end else begin
        MII_RXD   <= LINE_RXD;
        MII_RX_DV <= LINE_RX_DV;
      end
    end
  end

endmodule : phybc_basic_control

`default_nettype wire

// ---- phybc_basic_control_checker.sv ----
`timescale 1ns/100ps
`default_nettype none

// Watches control outputs against the register behaviour
module phybc_basic_control_checker (
  input wire logic       CORE_CLK,
  input wire logic       RST,
  input wire logic       INTERRUPT_POWERDOWN_PIN_N,
  input wire logic       AN_STARTED,
  input wire logic       AN_RESULT_100,
  input wire logic       AN_RESULT_FULL,
  input wire logic [3:0] MII_TXD,
  input wire logic       MII_TX_EN,
  input wire logic [3:0] LINE_RXD,
  input wire logic [3:0] MII_RXD,
  input wire logic       MII_RX_DV,
  input wire logic       MII_OE,
  input wire logic       MDIO_OUT,
  input wire logic       MDIO_OE,
  input wire logic       SOFT_RESET,
  input wire logic       LOOPBACK,
  input wire logic       SPEED_100,
  input wire logic       FULL_DUPLEX,
  input wire logic       AN_ENABLE,
  input wire logic       AN_RESTART,
  input wire logic       POWER_DOWN,
  input wire logic       ISOLATE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Data path modes and the soft reset pulse; three settled cycles so a mode change never counts
  sequence s_loop;
    LOOPBACK && !ISOLATE;
  endsequence
  sequence s_line;
    !LOOPBACK && !ISOLATE && !POWER_DOWN;
  endsequence
  sequence s_sr_ten;
    SOFT_RESET [*8] ##1 SOFT_RESET ##1 SOFT_RESET ##1 !SOFT_RESET;
  endsequence

  ////////////////////////////////////////////////////////////
  // Control outputs against their causes
  a_swrst_ten_cycles: assert property ($rose(SOFT_RESET) |-> s_sr_ten)
    else $error("soft reset pulse length wrong");
  a_swrst_defaults: assert property (SOFT_RESET |-> AN_ENABLE && !LOOPBACK && !ISOLATE)
    else $error("control bits not default during soft reset");
  a_an_overrides: assert property (!$past(RST) && AN_ENABLE |->
    SPEED_100 == $past(AN_RESULT_100) && FULL_DUPLEX == $past(AN_RESULT_FULL))
    else $error("forced speed or duplex used while negotiating");
  a_pin_powers_down: assert property (!INTERRUPT_POWERDOWN_PIN_N |=> POWER_DOWN)
    else $error("power-down pin ignored");
  a_isolate_mac_off: assert property (ISOLATE |-> !MII_OE && !MII_RX_DV)
    else $error("MAC side still driven while isolated");
  a_loop_returns_txd: assert property (s_loop ##1 s_loop ##1 s_loop |->
    MII_RXD == $past(MII_TXD) && MII_RX_DV == $past(MII_TX_EN))
    else $error("loopback data mismatch");
  a_line_to_mac: assert property (s_line ##1 s_line ##1 s_line |->
    MII_RXD == $past(LINE_RXD))
    else $error("receive data not from line side");
  a_restart_clears: assert property (AN_STARTED |-> ##2 !AN_RESTART)
    else $error("restart bit stuck after negotiation start");
  a_turnaround_zero: assert property ($rose(MDIO_OE) |-> !MDIO_OUT)
    else $error("turnaround bit not driven low");
  a_reset_defaults: assert property (disable iff (1'b0) RST |=> !SOFT_RESET &&
    SPEED_100 && AN_ENABLE && FULL_DUPLEX && !LOOPBACK && !ISOLATE && !POWER_DOWN
    && MII_OE && !MDIO_OE)
    else $error("wrong values after reset");
endmodule : phybc_basic_control_checker

bind phybc_basic_control phybc_basic_control_checker u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .INTERRUPT_POWERDOWN_PIN_N(INTERRUPT_POWERDOWN_PIN_N), .AN_STARTED(AN_STARTED),
  .AN_RESULT_100(AN_RESULT_100), .AN_RESULT_FULL(AN_RESULT_FULL), .MII_TXD(MII_TXD),
  .MII_TX_EN(MII_TX_EN), .LINE_RXD(LINE_RXD), .MII_RXD(MII_RXD), .MII_RX_DV(MII_RX_DV),
  .MII_OE(MII_OE), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE), .SOFT_RESET(SOFT_RESET),
  .LOOPBACK(LOOPBACK), .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX),
  .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART), .POWER_DOWN(POWER_DOWN),
  .ISOLATE(ISOLATE)
);

`default_nettype wire

// ---- phybc_sta_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Station manager: MDC stays low between frames
module phybc_sta_model (
  input  wire logic clk,
  input  wire logic mdio_wire,
  output logic      mdc,
  output logic      mdio_d,
  output logic      mdio_oe
);
  // Idle: nothing driven
  initial begin
    mdc = 1'b0;
    mdio_d = 1'b1;
    mdio_oe = 1'b0;
  end

  // One bit: 3 cycles low, 5 high; sample just before the rise, as the device
  // only updates its output after it sees that rise
  task automatic clk_bit(input logic drv, input logic b, output logic smp);
    @(posedge clk);
    mdc <= 1'b0;
    mdio_oe <= drv;
    mdio_d <= b;
    repeat (3) @(posedge clk);
    smp = mdio_wire;
    mdc <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : clk_bit

  // Full frame with 32-one preamble; read releases turnaround and data
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] hdr;
    logic        s;
    hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
    repeat (32) clk_bit(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      clk_bit(!(rd && i < 18), hdr[i], s);
      if (i < 16) q[i] = s;
    end
    @(posedge clk);
    mdc <= 1'b0;
    mdio_oe <= 1'b0;
  endtask : frame
endmodule : phybc_sta_model

`default_nettype wire

// ---- phybc_basic_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHECK_EQ(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t value %h expected %h", $time, (g), (e)); end end

module phybc_basic_control_tb;
  typedef struct packed {logic [15:0] wr; logic [15:0] rb; logic [6:0] o;} phybc_row_s;
  logic        clk, rst, pin_n, an_st, dup_strap, rx_err, link_ok, fcar, energy;
  logic        mdc, sta_d, sta_oe, mdio_out, mdio_oe, mdio_w, rx_dv, mii_oe, soft_rst;
  logic        lb, spd, fd, an_en, an_rst, pd, iso, coll, an_100;
  logic [3:0]  rxd;
  logic [15:0] q;
  logic [7:0]  cnt = 8'h00;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, sr_cnt = 0;
  // Rows: written word, read-back, {loop,speed,duplex,an,pwdn,isolate,coll}
  phybc_row_s  rows [8] = '{
    '{16'h4000, 16'h4000, 7'h40}, '{16'h2100, 16'h2100, 7'h30},
    '{16'h3100, 16'h3100, 7'h08}, '{16'h0800, 16'h0800, 7'h04},
    '{16'h0400, 16'h0400, 7'h02}, '{16'h0080, 16'h0080, 7'h01},
    '{16'h007F, 16'h0000, 7'h00}, '{16'h0200, 16'h0000, 7'h00}};

  // Shared MDIO line with pull-up when nobody drives
  assign mdio_w = mdio_oe ? mdio_out : (sta_oe ? sta_d : 1'b1);

  phybc_basic_control u_dut (
    .CORE_CLK(clk), .RST(rst), .MDC(mdc), .MDIO_IN(mdio_w), .MDIO_OUT(mdio_out),
    .MDIO_OE(mdio_oe), .PHY_ADDR_STRAP(5'h05), .DUPLEX_STRAP(dup_strap),
    .INTERRUPT_POWERDOWN_PIN_N(pin_n), .AN_STARTED(an_st), .AN_RESULT_100(an_100), .AN_RESULT_FULL(1'b0),
    .RX_ERROR(rx_err), .LINK_OK(link_ok), .FALSE_CARRIER(fcar), .ENERGY_DETECT(energy),
    .MII_TXD(cnt[3:0]), .MII_TX_EN(cnt[4]), .LINE_RXD(cnt[7:4]), .LINE_RX_DV(cnt[5]),
    .MII_RXD(rxd), .MII_RX_DV(rx_dv), .MII_OE(mii_oe), .SOFT_RESET(soft_rst),
    .LOOPBACK(lb), .SPEED_100(spd), .FULL_DUPLEX(fd), .AN_ENABLE(an_en),
    .AN_RESTART(an_rst), .POWER_DOWN(pd), .ISOLATE(iso), .COLLISION_TEST(coll)
  );
  phybc_sta_model u_sta (.clk(clk), .mdio_wire(mdio_w), .mdc(mdc), .mdio_d(sta_d),
                         .mdio_oe(sta_oe));

  ////////////////////////////////////////////////////////////
  // Clock, data pattern, soft reset length count and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    cyc <= cyc + 1;
    if (soft_rst) sr_cnt <= sr_cnt + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Waits past the write strobe so outputs have settled
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] dummy;
    u_sta.frame(1'b0, 5'h05, ra, wd, dummy);
    repeat (3) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [4:0] pa, input logic [4:0] ra);
    u_sta.frame(1'b1, pa, ra, 16'h0000, q);
  endtask : rd
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    pin_n = 1'b1;
    an_st = 1'b0;
    an_100 = 1'b0;
    dup_strap = 1'b1;
    rx_err = 1'b0;
    link_ok = 1'b1;
    fcar = 1'b0;
    energy = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(5'h05, 5'h00);
    `CHECK_EQ(q, 16'h3100)
    rd(5'h05, 5'h11);
    `CHECK_EQ(q, 16'h5002)
    foreach (rows[i]) begin
      wr(5'h00, rows[i].wr);
      `CHECK_EQ({lb, spd, fd, an_en, pd, iso, coll}, rows[i].o)
      `CHECK_EQ(an_rst, 1'b0)
      rd(5'h05, 5'h00);
      `CHECK_EQ(q, rows[i].rb)
    end
    // Restart needs negotiation on, then clears on start
    wr(5'h00, 16'h1200);
    `CHECK_EQ(an_rst, 1'b1)
    an_st <= 1'b1;
    @(posedge clk) an_st <= 1'b0;
    // Negotiated speed must follow its input, not forced bit 13
    an_100 <= 1'b1;
    repeat (2) @(posedge clk);
    `CHECK_EQ(spd, 1'b1)
    rd(5'h05, 5'h00);
    `CHECK_EQ(q, 16'h1000)
    // Pin low sets the power-down bit, which stays after release
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHECK_EQ(pd, 1'b1)
    pin_n <= 1'b1;
    rd(5'h05, 5'h00);
    `CHECK_EQ(q, 16'h1800)
    wr(5'h00, 16'h1000);
    `CHECK_EQ(pd, 1'b0)
    // Status kinds: one-cycle events with energy held high, then read twice
    rx_err <= 1'b1;
    fcar <= 1'b1;
    link_ok <= 1'b0;
    energy <= 1'b1;
    @(posedge clk);
    rx_err <= 1'b0;
    fcar <= 1'b0;
    link_ok <= 1'b1;
    rd(5'h05, 5'h11);
    `CHECK_EQ(q, 16'h500D)
    rd(5'h05, 5'h11);
    `CHECK_EQ(q, 16'h500A)
    energy <= 1'b0;
    wr(5'h11, 16'hFFFF);
    rd(5'h05, 5'h11);
    `CHECK_EQ(q, 16'h5002)
    // Unmapped register and foreign address
    rd(5'h05, 5'h02);
    `CHECK_EQ(q, 16'h0000)
    rd(5'h06, 5'h00);
    `CHECK_EQ(q, 16'hFFFF)
    // Soft reset clears loopback and relatches the new strap
    dup_strap <= 1'b0;
    wr(5'h00, 16'h4000);
    wr(5'h00, 16'h8000);
    repeat (20) @(posedge clk);
    `CHECK_EQ(sr_cnt, phybc_pkg::SWRST_CYCLES)
    rd(5'h05, 5'h00);
    `CHECK_EQ(q, 16'h3000)
    give_verdict();
  end
endmodule : phybc_basic_control_tb

`default_nettype wire
